// file: hw/ldc_pkg.sv
package ldc_pkg;
	// Tri-state mode pin as seen by logic: tied low, left open, tied high.
	localparam logic [1:0] MODE_GND = 2'h0;
	localparam logic [1:0] MODE_FLOAT = 2'h1;
	localparam logic [1:0] MODE_VCC = 2'h2;
	localparam int GROUPS = 4;
	localparam int CHANNELS = 6;
	localparam int BYTE_BITS = 8;
	localparam int FRAME_BITS = 32;
	// Dimming period and analog refresh interval, in divided system clock ticks.
	localparam int PWM_PERIOD = 256;
	localparam int DC_UPDATE_TICKS = 1280;
	localparam logic [8:0] DUTY_FULL = 9'h100;
	localparam logic [8:0] DUTY_MIN_SERIAL = 9'h002;
	// Reference clock and derived counts.
	localparam int REF_CLK_HZ = 100_000_000;
	localparam int SYS_DIV_DEF = 2;
	localparam int EN_LOW_MS = 10;
	localparam int EN_LOW_CYC_DEF = EN_LOW_MS * (REF_CLK_HZ / 1000);
	localparam int SER_HALF_DEF = 4;
	// Controller register byte offsets.
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_DIRECT = 5'h04;
	localparam logic [4:0] REG_FRAME = 5'h08;
	localparam logic [4:0] REG_DCLVL = 5'h0C;
	localparam logic [4:0] REG_CMD = 5'h10;
	localparam logic [4:0] REG_STATUS = 5'h14;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
endpackage : ldc_pkg

// file: hw/ldc_if.sv
`timescale 1ns/10ps
// Dimming pins between controller and driver. A level with its drive bit low is undriven.
interface ldc_if;
	logic [1:0] modeSel;
	logic [3:0] dimLvl;
	logic [3:0] dimDrive;
	logic [31:0] dcCode;
	modport host (output modeSel, output dimLvl, output dimDrive, output dcCode);
	modport dev (input modeSel, input dimLvl, input dimDrive, input dcCode);
endinterface : ldc_if

// file: hw/ldc_duty_pwm.sv
`timescale 1ns/10ps
module ldc_duty_pwm (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] count,
	input wire logic [8:0] duty,
	output logic pwmOn
);
	logic pwmOn_nxt;

	// Nine-bit duty lets a full-scale value keep the output on over the whole period.
	always_comb begin
		pwmOn_nxt = ({1'b0, count} < duty);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmOn <= 1'b0;
		end else begin
			pwmOn <= pwmOn_nxt;
		end
	end
endmodule : ldc_duty_pwm

// file: hw/ldc_device.sv
// Contract
// - Mode pin grounded selects direct dimming.
// - Mode pin open selects serial dimming.
// - Mode pin high selects DC dimming.
// - Channels 0/1, 2/3 shared; 4, 5 separate.
// - Undriven dimming input reads as off.
// - Direct mode: group on while input high.
// - Host holds each direct pulse 8 us.
// - Serial: A data, B clock, C frame end.
// - Frame bytes map to groups A..D.
// - Capture data on each bit clock rise.
// - Frame-end fall loads all four bytes.
// - Serial duty is (code+1)/256, zero off.
// - Codes one and two give 2/256.
// - Serial period is 256 ticks.
// - Host picks clock near 488 Hz dimming.
// - DC duty linear over input range.
// - DC duties refresh every 1280 ticks.
// - Rail sense at reference starts test.
// - Low drain during test disables channel.
// - Test runs once; disables persist.
// - Enable low 10 ms restarts, clears.
// - Host grounds group D in serial.
// - Cascade clock is half system clock.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module ldc_device #(
	parameter int SYS_DIV = ldc_pkg::SYS_DIV_DEF,
	parameter int EN_LOW_CYC = ldc_pkg::EN_LOW_CYC_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	ldc_if.dev link,
	input wire logic enable,
	input wire logic railFbAtRef,
	input wire logic [5:0] drainBelowTest,
	input wire logic faultCapExpired,
	output logic [5:0] chanGate,
	output logic [5:0] chanDisabled,
	output logic [5:0] headroomLoopMask,
	output logic ledTestDone,
	output logic cascadeClk
);
	typedef enum logic [1:0] {LDC_WAIT_RAIL, LDC_TESTING, LDC_RUN} ldc_test_e;

	// Group that drives a given channel.
	function automatic logic [1:0] chanGroup(input int ch);
		if (ch < 2) begin
			chanGroup = 2'h0;
		end else if (ch < 4) begin
			chanGroup = 2'h1;
		end else begin
			chanGroup = 2'(ch - 2);
		end
	endfunction : chanGroup

	// Serial code to duty; codes one and two both land on the two-step floor.
	function automatic logic [8:0] serialDuty(input logic [7:0] code);
		if (code == 8'h00) begin
			serialDuty = 9'h000;
		end else if (code < 8'h03) begin
			serialDuty = ldc_pkg::DUTY_MIN_SERIAL;
		end else begin
			serialDuty = {1'b0, code} + 9'h001;
		end
	endfunction : serialDuty

	// Analog code spans the input range linearly, top code forces full on.
	function automatic logic [8:0] dcDuty(input logic [7:0] code);
		dcDuty = (code == 8'hFF) ? ldc_pkg::DUTY_FULL : {1'b0, code};
	endfunction : dcDuty

	logic [15:0] divCnt_r, divCnt_nxt;
	logic tick_r, tick_nxt;
	logic casc_r, casc_nxt;
	logic [7:0] pwmCnt_r, pwmCnt_nxt;
	logic [10:0] dcCnt_r, dcCnt_nxt;
	logic [3:0] dimIn;

	// Undriven inputs fall to the off state, as a weak pull-down would make them.
	assign dimIn = link.dimLvl & link.dimDrive;

	// System clock divider, cascade clock and shared period counters.
	always_comb begin
		divCnt_nxt = divCnt_r + 16'h0001;
		tick_nxt = 1'b0;
		casc_nxt = casc_r;
		pwmCnt_nxt = pwmCnt_r;
		dcCnt_nxt = dcCnt_r;
		if (divCnt_r == 16'(SYS_DIV - 1)) begin
			divCnt_nxt = 16'h0000;
			tick_nxt = 1'b1;
		end
		if (tick_r) begin
			casc_nxt = ~casc_r;
			pwmCnt_nxt = pwmCnt_r + 8'h01;
			if (dcCnt_r == 11'(ldc_pkg::DC_UPDATE_TICKS - 1)) begin
				dcCnt_nxt = 11'h000;
			end else begin
				dcCnt_nxt = dcCnt_r + 11'h001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_r <= 16'h0000;
			tick_r <= 1'b0;
			casc_r <= 1'b0;
			pwmCnt_r <= 8'h00;
			dcCnt_r <= 11'h000;
		end else begin
			divCnt_r <= divCnt_nxt;
			tick_r <= tick_nxt;
			casc_r <= casc_nxt;
			pwmCnt_r <= pwmCnt_nxt;
			dcCnt_r <= dcCnt_nxt;
		end
	end

	logic serMode;
	logic bclkPrev_r, bclkPrev_nxt;
	logic eofPrev_r, eofPrev_nxt;
	logic [31:0] shift_r, shift_nxt;
	logic [31:0] serByte_r, serByte_nxt;
	logic [31:0] dcByte_r, dcByte_nxt;
	logic [31:0] dcIn;

	assign serMode = (link.modeSel == ldc_pkg::MODE_FLOAT);

	// Undriven analog inputs read as the bottom of the range.
	generate
		for (genvar g = 0; g < ldc_pkg::GROUPS; g++) begin : g_dcin
			assign dcIn[g*8 +: 8] = link.dimDrive[g] ? link.dcCode[g*8 +: 8] : 8'h00;
		end
	endgenerate

	// Serial shifter and frame latch; data A, bit clock B, frame end C.
	// The first byte shifted in ends up in the top byte and feeds group A.
	always_comb begin
		bclkPrev_nxt = dimIn[1];
		eofPrev_nxt = dimIn[2];
		shift_nxt = shift_r;
		serByte_nxt = serByte_r;
		dcByte_nxt = dcByte_r;
		if (serMode && dimIn[1] && !bclkPrev_r) begin
			shift_nxt = {shift_r[30:0], dimIn[0]};
		end
		if (serMode && !dimIn[2] && eofPrev_r) begin
			serByte_nxt = shift_r;
		end
		if (tick_r && dcCnt_r == 11'(ldc_pkg::DC_UPDATE_TICKS - 1)) begin
			dcByte_nxt = dcIn;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bclkPrev_r <= 1'b0;
			eofPrev_r <= 1'b0;
			shift_r <= 32'h0000_0000;
			serByte_r <= 32'h0000_0000;
			dcByte_r <= 32'h0000_0000;
		end else begin
			bclkPrev_r <= bclkPrev_nxt;
			eofPrev_r <= eofPrev_nxt;
			shift_r <= shift_nxt;
			serByte_r <= serByte_nxt;
			dcByte_r <= dcByte_nxt;
		end
	end

	logic [3:0] groupOn;

	// One duty comparator per group; group A takes the top serial byte and the bottom analog byte.
	generate
		for (genvar g = 0; g < ldc_pkg::GROUPS; g++) begin : g_pwm
			logic [7:0] sByte;
			logic [8:0] duty;
			logic pwmOn;
			assign sByte = serByte_r[31 - g*8 -: 8];
			assign duty = serMode ? serialDuty(sByte) : dcDuty(dcByte_r[g*8 +: 8]);
			ldc_duty_pwm u_pwm (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.count(pwmCnt_r),
				.duty(duty),
				.pwmOn(pwmOn)
			);
			always_comb begin
				unique case (link.modeSel)
					ldc_pkg::MODE_GND: groupOn[g] = dimIn[g];
					ldc_pkg::MODE_FLOAT: groupOn[g] = pwmOn;
					ldc_pkg::MODE_VCC: groupOn[g] = pwmOn;
					default: groupOn[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	ldc_test_e state_r, state_nxt;
	logic [5:0] dis_r, dis_nxt;
	logic [19:0] enLow_r, enLow_nxt;
	logic [5:0] gate_nxt;

	// Startup string test and enable-driven restart. A restart wins over everything.
	always_comb begin
		state_nxt = state_r;
		dis_nxt = dis_r;
		enLow_nxt = enable ? 20'h00000 : enLow_r;
		unique case (state_r)
			LDC_WAIT_RAIL: begin
				if (railFbAtRef) begin
					state_nxt = LDC_TESTING;
				end
			end
			LDC_TESTING: begin
				dis_nxt = dis_r | drainBelowTest;
				if (faultCapExpired) begin
					state_nxt = LDC_RUN;
				end
			end
			LDC_RUN: begin
				state_nxt = LDC_RUN;
			end
		endcase
		if (!enable) begin
			if (enLow_r == 20'(EN_LOW_CYC - 1)) begin
				state_nxt = LDC_WAIT_RAIL;
				dis_nxt = 6'h00;
			end else begin
				enLow_nxt = enLow_r + 20'h00001;
			end
		end
	end

	// Channels light only after the test, while enabled and not disabled.
	always_comb begin
		for (int c = 0; c < ldc_pkg::CHANNELS; c++) begin
			gate_nxt[c] = (state_r == LDC_RUN) && enable && !dis_r[c] && groupOn[chanGroup(c)];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= LDC_WAIT_RAIL;
			dis_r <= 6'h00;
			enLow_r <= 20'h00000;
			chanGate <= 6'h00;
			chanDisabled <= 6'h00;
			headroomLoopMask <= 6'h3F;
			ledTestDone <= 1'b0;
			cascadeClk <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dis_r <= dis_nxt;
			enLow_r <= enLow_nxt;
			chanGate <= gate_nxt;
			chanDisabled <= dis_nxt;
			headroomLoopMask <= ~dis_nxt;
			ledTestDone <= (state_nxt == LDC_RUN);
			cascadeClk <= casc_nxt;
		end
	end
endmodule : ldc_device

// file: hw/ldc_host.sv
`timescale 1ns/10ps
module ldc_host #(
	parameter int SER_HALF = ldc_pkg::SER_HALF_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	ldc_if.host link
);
	typedef enum logic [1:0] {LDC_IDLE, LDC_BIT_LOW, LDC_BIT_HIGH, LDC_EOF_LOW} ldc_tx_e;

	logic [31:0] ctrl_r, ctrl_nxt, direct_r, direct_nxt, frame_r, frame_nxt, dc_r, dc_nxt;
	logic [31:0] rdata_nxt;
	logic wait_nxt, acc, busy;
	logic sendReq;
	ldc_tx_e tx_r, tx_nxt;

	// Every access waits exactly one cycle; it completes on the edge where waitrequest is low.
	assign acc = (avs_read || avs_write) && !avs_waitrequest;
	assign busy = (tx_r != LDC_IDLE);
	assign sendReq = acc && avs_write && avs_address == ldc_pkg::REG_CMD && avs_writedata[0];

	always_comb begin
		ctrl_nxt = ctrl_r;
		direct_nxt = direct_r;
		frame_nxt = frame_r;
		dc_nxt = dc_r;
		wait_nxt = !((avs_read || avs_write) && avs_waitrequest);
		rdata_nxt = 32'h0000_0000;
		if (acc && avs_write) begin
			unique case (avs_address)
				ldc_pkg::REG_CTRL: ctrl_nxt = {30'h0000_0000, avs_writedata[1:0]};
				ldc_pkg::REG_DIRECT: direct_nxt = {24'h000000, avs_writedata[7:0]};
				ldc_pkg::REG_FRAME: frame_nxt = avs_writedata;
				ldc_pkg::REG_DCLVL: dc_nxt = avs_writedata;
				default: ;
			endcase
		end
		unique case (avs_address)
			ldc_pkg::REG_CTRL: rdata_nxt = ctrl_r;
			ldc_pkg::REG_DIRECT: rdata_nxt = direct_r;
			ldc_pkg::REG_FRAME: rdata_nxt = frame_r;
			ldc_pkg::REG_DCLVL: rdata_nxt = dc_r;
			ldc_pkg::REG_STATUS: rdata_nxt = {31'h0000_0000, busy};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= ldc_pkg::REG_RST;
			direct_r <= ldc_pkg::REG_RST;
			frame_r <= ldc_pkg::REG_RST;
			dc_r <= ldc_pkg::REG_RST;
			avs_readdata <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
		end else begin
			ctrl_r <= ctrl_nxt;
			direct_r <= direct_nxt;
			frame_r <= frame_nxt;
			dc_r <= dc_nxt;
			avs_readdata <= rdata_nxt;
			avs_waitrequest <= wait_nxt;
		end
	end

	logic [15:0] half_r, half_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic [31:0] txSh_r, txSh_nxt;
	logic [3:0] dim_nxt, drive_nxt;

	// Frame sender: data set while bit clock is low, MSB first, then frame-end pulse low.
	// A send request while a frame is going out is ignored.
	always_comb begin
		tx_nxt = tx_r;
		half_nxt = half_r + 16'h0001;
		bit_nxt = bit_r;
		txSh_nxt = txSh_r;
		if (half_r == 16'(SER_HALF - 1)) begin
			half_nxt = 16'h0000;
		end
		unique case (tx_r)
			LDC_IDLE: begin
				half_nxt = 16'h0000;
				if (sendReq) begin
					tx_nxt = LDC_BIT_LOW;
					txSh_nxt = frame_r;
					bit_nxt = 5'h00;
				end
			end
			LDC_BIT_LOW: begin
				if (half_r == 16'(SER_HALF - 1)) begin
					tx_nxt = LDC_BIT_HIGH;
				end
			end
			LDC_BIT_HIGH: begin
				if (half_r == 16'(SER_HALF - 1)) begin
					txSh_nxt = {txSh_r[30:0], 1'b0};
					bit_nxt = bit_r + 5'h01;
					tx_nxt = (bit_r == 5'(ldc_pkg::FRAME_BITS - 1)) ? LDC_EOF_LOW : LDC_BIT_LOW;
				end
			end
			LDC_EOF_LOW: begin
				if (half_r == 16'(SER_HALF - 1)) begin
					tx_nxt = LDC_IDLE;
				end
			end
		endcase
		if (ctrl_r[1:0] == ldc_pkg::MODE_FLOAT) begin
			dim_nxt = {1'b0, tx_nxt != LDC_EOF_LOW, tx_nxt == LDC_BIT_HIGH, txSh_nxt[31]};
			drive_nxt = 4'hF;
		end else begin
			dim_nxt = direct_r[3:0];
			drive_nxt = direct_r[7:4];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_r <= LDC_IDLE;
			half_r <= 16'h0000;
			bit_r <= 5'h00;
			txSh_r <= 32'h0000_0000;
			link.modeSel <= ldc_pkg::MODE_GND;
			link.dimLvl <= 4'h0;
			link.dimDrive <= 4'h0;
			link.dcCode <= 32'h0000_0000;
		end else begin
			tx_r <= tx_nxt;
			half_r <= half_nxt;
			bit_r <= bit_nxt;
			txSh_r <= txSh_nxt;
			link.modeSel <= ctrl_r[1:0];
			link.dimLvl <= dim_nxt;
			link.dimDrive <= drive_nxt;
			link.dcCode <= dc_r;
		end
	end
endmodule : ldc_host

// file: dv/ldc_checker_sva.sv
`timescale 1ns/10ps
// Watches the dimming pins and the driver's channel outputs side by side.
module ldc_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] modeSel,
	input wire logic [3:0] dimLvl,
	input wire logic [3:0] dimDrive,
	input wire logic enable,
	input wire logic ledTestDone,
	input wire logic [5:0] chanGate,
	input wire logic [5:0] chanDisabled,
	input wire logic [5:0] headroomLoopMask,
	input wire logic cascadeClk
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Gates lag the pins by one cycle, so four steady cycles are demanded first.
	a_direct_group_on: assert property (
		(modeSel == ldc_pkg::MODE_GND && enable && ledTestDone && dimLvl[0] && dimDrive[0]
		&& !chanDisabled[0])[*4] |-> chanGate[0])
		else $error("direct group A stays dark");
	a_undriven_dark: assert property (
		(modeSel == ldc_pkg::MODE_GND && !(dimLvl[2] && dimDrive[2]))[*4] |-> !chanGate[4])
		else $error("group C lit without a driven high input");
	a_pairs_shared: assert property (chanGate[0] == chanGate[1] && chanGate[2] == chanGate[3])
		else $error("paired channels differ");
	a_disabled_dark: assert property ((chanGate & chanDisabled) == 6'h00)
		else $error("disabled channel conducts");
	a_loop_mask: assert property (headroomLoopMask == ~chanDisabled)
		else $error("headroom loop mask disagrees with disables");
	a_test_once: assert property (ledTestDone && $past(ledTestDone) |-> $stable(chanDisabled))
		else $error("disables changed after the string test");
	a_enable_off: assert property (!enable [*3] |-> chanGate == 6'h00)
		else $error("channels lit with enable low");
	// Assumes two reference cycles per system tick, as the bench sets it.
	a_cascade_half: assert property (
		$changed(cascadeClk) |=> $stable(cascadeClk) ##1 $changed(cascadeClk))
		else $error("cascade clock not half the system tick");
	a_bit_clock_high: assert property (
		modeSel == ldc_pkg::MODE_FLOAT && $rose(dimLvl[1]) |-> dimLvl[1] [*4])
		else $error("bit clock high phase too short");
	a_serial_d_low: assert property (
		modeSel == ldc_pkg::MODE_FLOAT ##1 modeSel == ldc_pkg::MODE_FLOAT |-> !dimLvl[3])
		else $error("group D input not low in serial mode");
	c_frame_end: cover property (modeSel == ldc_pkg::MODE_FLOAT && $fell(dimLvl[2]));
	c_test_done: cover property ($rose(ledTestDone));
	c_direct_on: cover property (modeSel == ldc_pkg::MODE_GND && chanGate[0]);
endmodule : ldc_checker

// file: dv/led_group_dimming_control_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module led_group_dimming_control_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic enable = 1'b1;
	logic railFbAtRef = 1'b0;
	logic [5:0] drainBelowTest = 6'h00;
	logic faultCapExpired = 1'b0;
	logic [5:0] chanGate;
	logic [5:0] chanDisabled;
	logic [5:0] headroomLoopMask;
	logic ledTestDone;
	logic cascadeClk;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [31:0] pat;
	logic [8:0] ex[4];
	int gmap[6] = '{0, 0, 1, 1, 2, 3};
	ldc_if link ();
	ldc_host #(.SER_HALF(4)) ldc_host_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link));
	ldc_device #(.SYS_DIV(2), .EN_LOW_CYC(20)) ldc_device_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .link(link), .enable(enable), .railFbAtRef(railFbAtRef),
		.drainBelowTest(drainBelowTest), .faultCapExpired(faultCapExpired),
		.chanGate(chanGate), .chanDisabled(chanDisabled), .headroomLoopMask(headroomLoopMask),
		.ledTestDone(ledTestDone), .cascadeClk(cascadeClk));
	ldc_checker ldc_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n), .modeSel(link.modeSel),
		.dimLvl(link.dimLvl), .dimDrive(link.dimDrive), .enable(enable),
		.ledTestDone(ledTestDone), .chanGate(chanGate), .chanDisabled(chanDisabled),
		.headroomLoopMask(headroomLoopMask), .cascadeClk(cascadeClk));
	// Clock at 100 MHz.
	always #5 ref_clk = ~ref_clk;
	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// Hang guard, well above the roughly 12000 cycles the run needs.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			final_report();
		end
	end
	// One Avalon transfer; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic fault_end();
		@(posedge ref_clk) faultCapExpired <= 1'b1;
		@(posedge ref_clk) faultCapExpired <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask : fault_end
	function automatic logic [8:0] ser_duty(input logic [7:0] v);
		if (v == 8'h00)
			return 9'h000;
		if (v < 8'h03)
			return 9'h002;
		return {1'b0, v} + 9'h001;
	endfunction : ser_duty
	function automatic logic [5:0] expand(input logic [3:0] g);
		return {g[3], g[2], g[1], g[1], g[0], g[0]};
	endfunction : expand
	// One full period is 512 reference cycles, so any window counts the duty exactly.
	task automatic measure();
		logic [10:0] c[6];
		foreach (c[i]) c[i] = 11'h000;
		repeat (512) begin
			@(posedge ref_clk);
			foreach (c[i]) c[i] += chanGate[i];
		end
		foreach (c[i]) `CHK("duty", {1'b0, ex[gmap[i]], 1'b0}, c[i])
	endtask : measure
	initial begin
		void'($urandom(32'hC5AE));
		repeat (3) @(posedge ref_clk);
		`CHK("mask", 6'h3F, headroomLoopMask)
		`CHK("mode", 2'h0, link.modeSel)
		rst_n <= 1'b1;
		// String test, then a restart that clears the disables.
		pat = $urandom & 32'h3E;
		drainBelowTest <= pat[5:0];
		repeat (4) @(posedge ref_clk);
		railFbAtRef <= 1'b1;
		repeat (8) @(posedge ref_clk);
		fault_end();
		`CHK("done", 1'b1, ledTestDone)
		`CHK("dis", pat[5:0], chanDisabled)
		drainBelowTest <= 6'h3F;
		fault_end();
		`CHK("keep", pat[5:0], chanDisabled)
		enable <= 1'b0;
		railFbAtRef <= 1'b0;
		drainBelowTest <= 6'h00;
		repeat (25) @(posedge ref_clk);
		enable <= 1'b1;
		railFbAtRef <= 1'b1;
		repeat (8) @(posedge ref_clk);
		fault_end();
		`CHK("clr", 6'h00, chanDisabled)
		for (int m = 2; m >= 0; m--) begin
			bus(1'b1, ldc_pkg::REG_CTRL, 32'(m));
			bus(1'b0, ldc_pkg::REG_CTRL, 32'h0);
			`CHK("mode", 2'(m), link.modeSel)
		end
		bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
		bus(1'b0, 5'h1C, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		// The unused fourth mode code must leave every channel dark, even with all groups high.
		bus(1'b1, ldc_pkg::REG_DIRECT, 32'hFF);
		bus(1'b1, ldc_pkg::REG_CTRL, 32'h3);
		repeat (5) @(posedge ref_clk);
		`CHK("illegal", 6'h00, chanGate)
		bus(1'b1, ldc_pkg::REG_CTRL, 32'h0);
		repeat (8) begin
			pat = $urandom;
			bus(1'b1, ldc_pkg::REG_DIRECT, pat & 32'hFF);
			repeat (5) @(posedge ref_clk);
			`CHK("gate", expand(pat[3:0] & pat[7:4]), chanGate)
		end
		bus(1'b1, ldc_pkg::REG_CTRL, 32'h1);
		for (int f = 0; f < 3; f++) begin
			pat = (f == 0) ? 32'h00FF_0102 : (f == 1) ? 32'h0201_FF00 : $urandom;
			foreach (ex[g]) ex[g] = ser_duty(pat[31 - 8 * g -: 8]);
			bus(1'b1, ldc_pkg::REG_FRAME, pat);
			bus(1'b1, ldc_pkg::REG_CMD, 32'h1);
			rd = 32'h1;
			for (int k = 0; k < 400 && rd[0] !== 1'b0; k++)
				bus(1'b0, ldc_pkg::REG_STATUS, 32'h0);
			`CHK("busy", 1'b0, rd[0])
			repeat (600) @(posedge ref_clk);
			measure();
		end
		// Analog inputs need their drive bits set, else they read as the bottom of the range.
		bus(1'b1, ldc_pkg::REG_DIRECT, 32'hF0);
		bus(1'b1, ldc_pkg::REG_CTRL, 32'h2);
		for (int f = 0; f < 2; f++) begin
			pat = f ? 32'h00FF_00FF : 32'hFF00_FF00;
			foreach (ex[g]) ex[g] = (pat[8 * g +: 8] == 8'hFF) ? 9'h100 : 9'h000;
			bus(1'b1, ldc_pkg::REG_DCLVL, pat);
			// The register lands at the accepting edge and reaches the pins one edge later.
			repeat (2) @(posedge ref_clk);
			`CHK("dc", pat, link.dcCode)
			repeat (3200) @(posedge ref_clk);
			measure();
		end
		final_report();
	end
endmodule : led_group_dimming_control_tb
